// file: common/dgout_map.svh
// register offsets, field positions, reset values and timing counts
// of the switched digital output controller
// assumes inclusion by bare name from the package and the design files
`ifndef DGOUT_MAP_SVH
`define DGOUT_MAP_SVH

// register bus geometry
`define DGOUT_ADDR_W 8
`define DGOUT_DATA_W 32
`define DGOUT_CH_STRIDE 8'h10

// per-channel register offsets inside one stride
`define DGOUT_OFF_CTRL 8'h00
`define DGOUT_OFF_ONTIME 8'h04
`define DGOUT_OFF_RATE 8'h08
`define DGOUT_OFF_CMDSTAT 8'h0C

// control register fields
`define DGOUT_CTRL_MODE_LSB 0
`define DGOUT_CTRL_BEHAV_LSB 2
`define DGOUT_CTRL_DSYS_LSB 4
`define DGOUT_CTRL_ESEL_LSB 6
`define DGOUT_CTRL_AMASK_LSB 8
`define DGOUT_CTRL_USED_W 16

// command register bits (write side)
`define DGOUT_CMD_ON 0
`define DGOUT_CMD_OFF 1
`define DGOUT_CMD_RELEASE 2

// status register bits (read side)
`define DGOUT_ST_OUT 0
`define DGOUT_ST_ASSOC_ALARM 1
`define DGOUT_ST_ASSOC_DEMAND 2
`define DGOUT_ST_ASSOC_ENERGY 3
`define DGOUT_ST_TIMING 4
`define DGOUT_ST_BAD_COMBO 5
`define DGOUT_ST_KEEP 6

// widths
`define DGOUT_ONTIME_W 14
`define DGOUT_RATE_W 16
`define DGOUT_ALARM_N 8
`define DGOUT_DEMAND_N 3
`define DGOUT_ENERGY_N 4
`define DGOUT_SUB_W 28

// reset values
`define DGOUT_CTRL_RST 16'h0000
`define DGOUT_ONTIME_RST 14'h0001
`define DGOUT_RATE_RST 16'h0001

// limits
`define DGOUT_ONTIME_MAX 14'h270F
`define DGOUT_ENERGY_SUBDIV 16'h03E8
`define DGOUT_DSYS_NONE 2'h3

// timing
`define DGOUT_CLK_PERIOD_NS 4
`define DGOUT_SECOND_NS 1000000000
`define DGOUT_SEC_CYCLES (`DGOUT_SECOND_NS / `DGOUT_CLK_PERIOD_NS)

`endif

// file: common/dgout_pkg.sv
// types of the switched digital output controller
// assumes dgout_map.svh is on the include path
`include "dgout_map.svh"

package dgout_pkg;

   // source that drives an output
   typedef enum logic [1:0] {
      CTRL_EXTERNAL,
      CTRL_DEMAND,
      CTRL_ALARM,
      CTRL_ENERGY
   } dgout_ctrl_t;

   // how long an output stays on
   typedef enum logic [1:0] {
      BEHAV_NORMAL,
      BEHAV_TIMED,
      BEHAV_HOLD,
      BEHAV_SPARE
   } dgout_behav_t;

   // output state of one channel
   typedef enum logic [1:0] {
      ST_OFF,
      ST_ON_STEADY,
      ST_ON_TIMED
   } dgout_state_t;

endpackage

// file: design/dgout_channel.sv
// one switched output: state machine and on-time timer
// assumes trigger, clear and restore strobes are one-cycle pulses on clk
`timescale 1ns/100ps
`default_nettype none
`include "dgout_map.svh"

module dgout_channel #(
   parameter int unsigned SEC_CYCLES = `DGOUT_SEC_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // setup
   input wire logic [`DGOUT_ONTIME_W-1:0] on_time,
   // strobes
   input wire logic start_timed,
   input wire logic set_steady,
   input wire logic clear_out,
   input wire logic restore_en,
   input wire logic restore_val,
   // state
   output logic out_q,
   output logic timing
);

   localparam logic [`DGOUT_SUB_W-1:0] SUB_LAST = `DGOUT_SUB_W'(SEC_CYCLES - 1);

   dgout_pkg::dgout_state_t state_reg;
   dgout_pkg::dgout_state_t state_next;
   logic [`DGOUT_SUB_W-1:0] sub_reg;
   logic [`DGOUT_ONTIME_W-1:0] sec_reg;
   logic sub_last;
   logic expire;

   ////////////////////////////////////////////////////////////////////
   // one-second divider restarted at every start, so width is exact
   assign sub_last = (sub_reg == SUB_LAST);
   assign expire = (sec_reg == '0) || (sub_last && sec_reg == `DGOUT_ONTIME_W'(1));

   // next state: restore, then new triggers, then clear, then expiry
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         dgout_pkg::ST_OFF,
         dgout_pkg::ST_ON_STEADY,
         dgout_pkg::ST_ON_TIMED: begin
            if (restore_en) begin
               state_next = restore_val ? dgout_pkg::ST_ON_STEADY : dgout_pkg::ST_OFF;
            end else if (start_timed) begin
               state_next = dgout_pkg::ST_ON_TIMED;
            end else if (set_steady) begin
               state_next = dgout_pkg::ST_ON_STEADY;
            end else if (clear_out) begin
               state_next = dgout_pkg::ST_OFF;
            end else if (state_reg == dgout_pkg::ST_ON_TIMED && expire) begin
               state_next = dgout_pkg::ST_OFF;
            end
         end
         default: begin
            state_next = dgout_pkg::ST_OFF;
         end
      endcase
   end

   // state and output flip-flops
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_reg <= dgout_pkg::ST_OFF;
         out_q <= 1'b0;
         timing <= 1'b0;
      end else begin
         state_reg <= state_next;
         out_q <= (state_next != dgout_pkg::ST_OFF);
         timing <= (state_next == dgout_pkg::ST_ON_TIMED);
      end
   end

   // on-time counters, loaded on every start
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sub_reg <= '0;
         sec_reg <= '0;
      end else if (start_timed && !restore_en) begin
         sub_reg <= '0;
         sec_reg <= on_time;
      end else if (state_reg == dgout_pkg::ST_ON_TIMED) begin
         if (sub_last) begin
            sub_reg <= '0;
            if (sec_reg != '0) begin
               sec_reg <= sec_reg - `DGOUT_ONTIME_W'(1);
            end
         end else begin
            sub_reg <= sub_reg + `DGOUT_SUB_W'(1);
         end
      end
   end

endmodule
`default_nettype wire

// file: design/dgout_top.sv
// switched digital output controller: registers, source selection,
// energy pulse generation and two output channels
// assumes event inputs are one-cycle pulses synchronous to CLK and
// a retained-state store outside that feeds HOLD_KEEP_IN back
//
// Overview of operation
// - There are two outputs, each with its own control mode, behaviour mode and on-time.
// - In external mode an output follows only on and off commands from the host.
// - In demand mode an output pulses at the end of each interval of its chosen demand system.
// - In alarm mode an output turns on whenever one of its selected alarms triggers.
// - In energy mode an output pulses at the set rate per unit of the chosen energy quantity.
// - In normal behaviour, for external or alarm control, an output stays on until an off command.
// - In timed behaviour an output stays on for exactly the on-time (one clock for an on-time of 0) and then turns off.
// - The on-time is in whole seconds and accepts 0 through 9999.
// - In hold behaviour, for external or alarm control, energize turns on and only release turns off.
// - In hold behaviour the state at power loss is kept and restored when power returns.
// - Software can read whether an output is tied to an alarm, demand or energy function.
`timescale 1ns/100ps
`default_nettype none
`include "dgout_map.svh"

module dgout_top #(
   parameter int unsigned SEC_CYCLES = `DGOUT_SEC_CYCLES
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // register port
   input wire logic [`DGOUT_ADDR_W-1:0] ADDR,
   input wire logic [`DGOUT_DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [`DGOUT_DATA_W-1:0] RDATA,
   // meter function events
   input wire logic [`DGOUT_DEMAND_N-1:0] DEMAND_END,
   input wire logic [`DGOUT_ALARM_N-1:0] ALARM_TRIG,
   input wire logic [`DGOUT_ENERGY_N-1:0] ENERGY_TICK,
   // retained hold state
   input wire logic HOLD_RESTORE,
   input wire logic [1:0] HOLD_KEEP_IN,
   output logic [1:0] HOLD_KEEP_OUT,
   // switched outputs
   output logic SWITCHED_OUTPUT_ONE,
   output logic SWITCHED_OUTPUT_TWO
);

   localparam int NCH = 2;

   ////////////////////////////////////////////////////////////////////
   // address decode shared by write and read paths
   function automatic logic dgout_hit(input logic [`DGOUT_ADDR_W-1:0] addr,
                                      input int ch,
                                      input logic [`DGOUT_ADDR_W-1:0] off);
      logic [`DGOUT_ADDR_W-1:0] base;
      base = `DGOUT_ADDR_W'(ch * `DGOUT_CH_STRIDE);
      return addr == (base + off);
   endfunction

   // clamps a written on-time into its legal range
   function automatic logic [`DGOUT_ONTIME_W-1:0] dgout_clamp_ontime(
      input logic [`DGOUT_DATA_W-1:0] val);
      logic [`DGOUT_ONTIME_W-1:0] res;
      if (val > `DGOUT_DATA_W'(`DGOUT_ONTIME_MAX)) begin
         res = `DGOUT_ONTIME_MAX;
      end else begin
         res = val[`DGOUT_ONTIME_W-1:0];
      end
      return res;
   endfunction

   // per-channel registers and state
   logic [`DGOUT_CTRL_USED_W-1:0] ctrl_reg [NCH];
   logic [`DGOUT_ONTIME_W-1:0] ontime_reg [NCH];
   logic [`DGOUT_RATE_W-1:0] rate_reg [NCH];
   logic [`DGOUT_RATE_W-1:0] acc_reg [NCH];
   logic [`DGOUT_DATA_W-1:0] stat_word [NCH];
   logic [NCH-1:0] out_q;
   logic [NCH-1:0] timing;
   logic [NCH-1:0] keep_next;
   logic [`DGOUT_DATA_W-1:0] rdata_next;

   ////////////////////////////////////////////////////////////////////
   // one independent set of setup and logic per output
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gen_ch
         dgout_pkg::dgout_ctrl_t mode;
         dgout_pkg::dgout_behav_t behav;
         logic [1:0] dsys;
         logic [1:0] esel;
         logic [`DGOUT_ALARM_N-1:0] amask;
         logic cmd_wr;
         logic cmd_on;
         logic cmd_off;
         logic cmd_release;
         logic cmd_ok;
         logic demand_ev;
         logic alarm_ev;
         logic energy_tick_sel;
         logic [`DGOUT_RATE_W:0] acc_sum;
         logic energy_ev;
         logic pulse_ev;
         logic start_timed;
         logic set_steady;
         logic clear_out;
         logic restore_en;
         logic assoc_alarm;
         logic assoc_demand;
         logic assoc_energy;
         logic bad_combo;

         // field split of the control register
         assign mode = dgout_pkg::dgout_ctrl_t'(ctrl_reg[g][`DGOUT_CTRL_MODE_LSB +: 2]);
         assign behav = dgout_pkg::dgout_behav_t'(ctrl_reg[g][`DGOUT_CTRL_BEHAV_LSB +: 2]);
         assign dsys = ctrl_reg[g][`DGOUT_CTRL_DSYS_LSB +: 2];
         assign esel = ctrl_reg[g][`DGOUT_CTRL_ESEL_LSB +: 2];
         assign amask = ctrl_reg[g][`DGOUT_CTRL_AMASK_LSB +: `DGOUT_ALARM_N];

         // setup register writes
         always_ff @(posedge CLK) begin
            if (!RST_B) begin
               ctrl_reg[g] <= `DGOUT_CTRL_RST;
               ontime_reg[g] <= `DGOUT_ONTIME_RST;
               rate_reg[g] <= `DGOUT_RATE_RST;
            end else if (WR) begin
               if (dgout_hit(ADDR, g, `DGOUT_OFF_CTRL)) begin
                  ctrl_reg[g] <= WDATA[`DGOUT_CTRL_USED_W-1:0];
               end
               if (dgout_hit(ADDR, g, `DGOUT_OFF_ONTIME)) begin
                  ontime_reg[g] <= dgout_clamp_ontime(WDATA);
               end
               if (dgout_hit(ADDR, g, `DGOUT_OFF_RATE)) begin
                  // rate above one pulse per tick is held at that ceiling
                  if (WDATA[`DGOUT_RATE_W-1:0] > `DGOUT_ENERGY_SUBDIV) begin
                     rate_reg[g] <= `DGOUT_ENERGY_SUBDIV;
                  end else begin
                     rate_reg[g] <= WDATA[`DGOUT_RATE_W-1:0];
                  end
               end
            end
         end

         // command strobes from a write to the command address
         assign cmd_wr = WR && dgout_hit(ADDR, g, `DGOUT_OFF_CMDSTAT);
         assign cmd_on = cmd_wr && WDATA[`DGOUT_CMD_ON];
         assign cmd_off = cmd_wr && WDATA[`DGOUT_CMD_OFF];
         assign cmd_release = cmd_wr && WDATA[`DGOUT_CMD_RELEASE];
         // commands act only in external and alarm control
         assign cmd_ok = (mode == dgout_pkg::CTRL_EXTERNAL) || (mode == dgout_pkg::CTRL_ALARM);

         // end of interval of the chosen demand system
         assign demand_ev = (mode == dgout_pkg::CTRL_DEMAND) && (dsys != `DGOUT_DSYS_NONE)
                            && DEMAND_END[dsys];

         // any selected alarm triggering
         assign alarm_ev = (mode == dgout_pkg::CTRL_ALARM) && |(ALARM_TRIG & amask);

         // energy: add rate per tick, fire once a whole unit is gathered
         assign energy_tick_sel = (mode == dgout_pkg::CTRL_ENERGY) && ENERGY_TICK[esel];
         assign acc_sum = {1'b0, acc_reg[g]} + {1'b0, rate_reg[g]};
         assign energy_ev = energy_tick_sel
                            && (acc_sum >= {1'b0, `DGOUT_ENERGY_SUBDIV});

         always_ff @(posedge CLK) begin
            if (!RST_B) begin
               acc_reg[g] <= '0;
            end else if (mode != dgout_pkg::CTRL_ENERGY) begin
               acc_reg[g] <= '0;
            end else if (energy_tick_sel) begin
               if (energy_ev) begin
                  acc_reg[g] <= acc_sum[`DGOUT_RATE_W-1:0] - `DGOUT_ENERGY_SUBDIV;
               end else begin
                  acc_reg[g] <= acc_sum[`DGOUT_RATE_W-1:0];
               end
            end
         end

         // demand and energy always make a timed pulse
         assign pulse_ev = demand_ev || energy_ev;

         // trigger decode per behaviour mode
         assign start_timed = pulse_ev
            || (alarm_ev && behav == dgout_pkg::BEHAV_TIMED)
            || (mode == dgout_pkg::CTRL_EXTERNAL && cmd_on
                && behav == dgout_pkg::BEHAV_TIMED);
         assign set_steady = (behav != dgout_pkg::BEHAV_TIMED) && cmd_ok
            && (alarm_ev || (mode == dgout_pkg::CTRL_EXTERNAL && cmd_on));
         // hold ignores off and answers only release
         assign clear_out = cmd_ok && ((behav == dgout_pkg::BEHAV_HOLD) ? cmd_release
                                                                      : cmd_off);
         assign restore_en = HOLD_RESTORE && cmd_ok
                             && (behav == dgout_pkg::BEHAV_HOLD);

         dgout_channel #(
            .SEC_CYCLES(SEC_CYCLES)
         ) u_channel (
            .clk(CLK),
            .rst_b(RST_B),
            .on_time(ontime_reg[g]),
            .start_timed(start_timed),
            .set_steady(set_steady),
            .clear_out(clear_out),
            .restore_en(restore_en),
            .restore_val(HOLD_KEEP_IN[g]),
            .out_q(out_q[g]),
            .timing(timing[g])
         );

         // associations reported to software
         assign assoc_alarm = (mode == dgout_pkg::CTRL_ALARM) && (amask != '0);
         assign assoc_demand = (mode == dgout_pkg::CTRL_DEMAND)
                               && (dsys != `DGOUT_DSYS_NONE);
         assign assoc_energy = (mode == dgout_pkg::CTRL_ENERGY);
         // normal and hold are meant for external or alarm control only
         assign bad_combo = (!cmd_ok && behav != dgout_pkg::BEHAV_TIMED)
                            || (behav == dgout_pkg::BEHAV_SPARE);

         // retained state follows the output while holding
         assign keep_next[g] = (behav == dgout_pkg::BEHAV_HOLD) && cmd_ok && out_q[g];

         always_comb begin
            stat_word[g] = '0;
            stat_word[g][`DGOUT_ST_OUT] = out_q[g];
            stat_word[g][`DGOUT_ST_ASSOC_ALARM] = assoc_alarm;
            stat_word[g][`DGOUT_ST_ASSOC_DEMAND] = assoc_demand;
            stat_word[g][`DGOUT_ST_ASSOC_ENERGY] = assoc_energy;
            stat_word[g][`DGOUT_ST_TIMING] = timing[g];
            stat_word[g][`DGOUT_ST_BAD_COMBO] = bad_combo;
            stat_word[g][`DGOUT_ST_KEEP] = HOLD_KEEP_OUT[g];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // read mux; unmapped addresses read zero
   always_comb begin
      rdata_next = '0;
      for (int c = 0; c < NCH; c++) begin
         if (dgout_hit(ADDR, c, `DGOUT_OFF_CTRL)) begin
            rdata_next = `DGOUT_DATA_W'(ctrl_reg[c]);
         end
         if (dgout_hit(ADDR, c, `DGOUT_OFF_ONTIME)) begin
            rdata_next = `DGOUT_DATA_W'(ontime_reg[c]);
         end
         if (dgout_hit(ADDR, c, `DGOUT_OFF_RATE)) begin
            rdata_next = `DGOUT_DATA_W'(rate_reg[c]);
         end
         if (dgout_hit(ADDR, c, `DGOUT_OFF_CMDSTAT)) begin
            rdata_next = stat_word[c];
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         RDATA <= '0;
      end else if (RD) begin
         RDATA <= rdata_next;
      end else begin
         RDATA <= '0;
      end
   end

   // retained state to the store outside
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         HOLD_KEEP_OUT <= '0;
      end else begin
         HOLD_KEEP_OUT <= keep_next;
      end
   end

   // switched outputs, one flip-flop stage after each channel
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         SWITCHED_OUTPUT_ONE <= 1'b0;
         SWITCHED_OUTPUT_TWO <= 1'b0;
      end else begin
         SWITCHED_OUTPUT_ONE <= out_q[0];
         SWITCHED_OUTPUT_TWO <= out_q[1];
      end
   end

endmodule
`default_nettype wire

// file: test/dgout_checker.sv
// assertions on the ports of the switched output controller
// assumes a bind onto dgout_top, one clock, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "dgout_map.svh"

module dgout_checker #(
   parameter int unsigned SEC_CYCLES = 10
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // register port
   input wire logic WR,
   input wire logic RD,
   input wire logic [`DGOUT_DATA_W-1:0] RDATA,
   // meter events
   input wire logic [`DGOUT_DEMAND_N-1:0] DEMAND_END,
   input wire logic [`DGOUT_ALARM_N-1:0] ALARM_TRIG,
   input wire logic [`DGOUT_ENERGY_N-1:0] ENERGY_TICK,
   // retained hold state
   input wire logic HOLD_RESTORE,
   input wire logic [1:0] HOLD_KEEP_OUT,
   // switched outputs
   input wire logic SWITCHED_OUTPUT_ONE,
   input wire logic SWITCHED_OUTPUT_TWO
);
   logic [3:0] cause_sh;
   logic [3:0] wr_sh;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   ////////////////////////////////////////////////////////////////////////////////
   // history of anything that may legally move an output
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         cause_sh <= 4'h0;
         wr_sh <= 4'h0;
      end else begin
         cause_sh <= {cause_sh[2:0], WR | HOLD_RESTORE | (|DEMAND_END) | (|ALARM_TRIG)
                      | (|ENERGY_TICK)};
         wr_sh <= {wr_sh[2:0], WR | HOLD_RESTORE};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read port and output causes
   chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data not zero outside the read slot");
   chk_rdata_upper: assert property (RDATA[31:16] == 16'h0)
      else $error("read data upper half not zero");
   // a cause taken at one edge shows on the pin at the next edge
   chk_one_rise_cause: assert property ($rose(SWITCHED_OUTPUT_ONE) |-> cause_sh[1])
      else $error("output one rose without command or event");
   chk_two_rise_cause: assert property ($rose(SWITCHED_OUTPUT_TWO) |-> cause_sh[1])
      else $error("output two rose without command or event");
   // retained state and pin come from the same channel flop
   chk_keep_one_on: assert property ($rose(HOLD_KEEP_OUT[0]) |-> SWITCHED_OUTPUT_ONE)
      else $error("retained state one set while output one off");
   chk_keep_two_on: assert property ($rose(HOLD_KEEP_OUT[1]) |-> SWITCHED_OUTPUT_TWO)
      else $error("retained state two set while output two off");
   chk_keep_one_hold: assert property ($fell(HOLD_KEEP_OUT[0]) |-> |wr_sh)
      else $error("held output one dropped without release");
   chk_keep_two_hold: assert property ($fell(HOLD_KEEP_OUT[1]) |-> |wr_sh)
      else $error("held output two dropped without release");
endmodule
`default_nettype wire

// file: test/dgout_relay_model.sv
// far-side model: relay coil or receiving meter input on one output
// assumes the output is sampled on the controller clock
`timescale 1ns/100ps
`default_nettype none

module dgout_relay_model (
   // clock
   input wire logic clk,
   // switched output under watch
   input wire logic coil,
   // tally of pulses seen and width of the last one
   output logic [31:0] pulses,
   output logic [31:0] width
);
   logic [31:0] run = 32'h0;
   logic coil_q = 1'b0;

   initial pulses = 32'h0;
   initial width = 32'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // count energisations and measure each one, as a pulse counter does
   always @(posedge clk) begin
      coil_q <= coil;
      if (coil && !coil_q) begin
         pulses <= pulses + 32'h1;
      end
      if (coil) begin
         run <= run + 32'h1;
      end else if (run != 32'h0) begin
         width <= run;
         run <= 32'h0;
      end
   end
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the switched output controller
// assumes design, header and far-side model are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "dgout_map.svh"

module tb;
   localparam int unsigned SEC = 10;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [2:0] dem = 3'h0;
   logic [7:0] alm = 8'h00;
   logic [3:0] eng = 4'h0;
   logic restore = 1'b0;
   logic [1:0] keep_in = 2'h0;
   logic [1:0] keep_out;
   logic out1, out2;
   logic [31:0] rdata, p1, w1, p2, w2, got, n;
   int err_total = 0;
   int n_checks = 0;

   always #2 clk = ~clk;

   // design and one far-side model per output
   dgout_top #(.SEC_CYCLES(SEC)) i_dgout_top (
      .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .DEMAND_END(dem), .ALARM_TRIG(alm), .ENERGY_TICK(eng),
      .HOLD_RESTORE(restore), .HOLD_KEEP_IN(keep_in), .HOLD_KEEP_OUT(keep_out),
      .SWITCHED_OUTPUT_ONE(out1), .SWITCHED_OUTPUT_TWO(out2));
   dgout_relay_model i_dgout_relay_model (.clk(clk), .coil(out1), .pulses(p1), .width(w1));
   dgout_relay_model i_dgout_relay_model_two (.clk(clk), .coil(out2), .pulses(p2), .width(w2));

   ////////////////////////////////////////////////////////////////////////////////
   // bus cycles, events and comparison
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(what, exp, rdata);
   endtask
   task automatic evt(input logic [2:0] d, input logic [7:0] a, input logic [3:0] e);
      @(posedge clk);
      dem <= d;
      alm <= a;
      eng <= e;
      @(posedge clk);
      dem <= 3'h0;
      alm <= 8'h00;
      eng <= 4'h0;
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
   endtask
   task automatic done(input string name);
      $display("test %s done", name);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // test sequence
   initial begin
      do_reset();
      wreg(8'h20, 32'hFFFF);
      rchk(8'h00, 32'h0, "ctrl one");
      rchk(8'h04, 32'h1, "ontime one");
      rchk(8'h08, 32'h1, "rate one");
      rchk(8'h14, 32'h1, "ontime two");
      rchk(8'h20, 32'h0, "unmapped");
      rchk(8'h0C, 32'h0, "status one");
      wreg(8'h04, 32'h2710);
      rchk(8'h04, 32'h270F, "ontime clamp");
      done("registers");
      // commanded timed pulses, zero on-time and retrigger
      wreg(8'h00, 32'h4);
      wreg(8'h04, 32'h2);
      n = p1;
      wreg(8'h0C, 32'h1);
      idle(30);
      chk("width", 32'(2 * SEC), w1);
      chk("pulses", n + 32'h1, p1);
      wreg(8'h04, 32'h0);
      wreg(8'h0C, 32'h1);
      idle(5);
      chk("zero width", 32'h1, w1);
      wreg(8'h04, 32'h1);
      wreg(8'h0C, 32'h1);
      wreg(8'h0C, 32'h1);
      idle(20);
      chk("retrigger width", 32'(SEC + 2), w1);
      chk("other output", 32'h0, p2);
      done("timed");
      // steady on until off, events ignored
      wreg(8'h00, 32'h0);
      evt(3'h7, 8'hFF, 4'hF);
      idle(4);
      chk("event ignored", 32'h0, {31'h0, out1});
      wreg(8'h0C, 32'h1);
      idle(40);
      rchk(8'h0C, 32'h1, "steady status");
      wreg(8'h0C, 32'h2);
      idle(3);
      chk("off", 32'h0, {31'h0, out1});
      done("normal");
      // demand interval pulses on the chosen system only
      wreg(8'h10, 32'h15);
      wreg(8'h14, 32'h1);
      rchk(8'h1C, 32'h4, "demand assoc");
      n = p2;
      wreg(8'h1C, 32'h1);
      evt(3'h5, 8'h00, 4'h0);
      idle(15);
      chk("demand other", n, p2);
      evt(3'h2, 8'h00, 4'h0);
      idle(15);
      chk("demand pulse", n + 32'h1, p2);
      chk("demand width", 32'(SEC), w2);
      // no demand system and the spare behaviour code
      wreg(8'h10, 32'h3D);
      rchk(8'h1C, 32'h20, "no demand system");
      n = p2;
      evt(3'h7, 8'h00, 4'h0);
      idle(15);
      chk("demand none", n, p2);
      done("demand");
      // masked alarm triggers a timed pulse
      wreg(8'h00, 32'h0406);
      wreg(8'h04, 32'h1);
      rchk(8'h0C, 32'h2, "alarm assoc");
      n = p1;
      evt(3'h0, 8'hFB, 4'h0);
      idle(15);
      chk("alarm masked", n, p1);
      evt(3'h0, 8'h04, 4'h0);
      idle(15);
      chk("alarm pulse", n + 32'h1, p1);
      chk("alarm width", 32'(SEC), w1);
      done("alarm");
      // energy ticks scaled by the rate
      wreg(8'h18, 32'h7D0);
      rchk(8'h18, 32'h3E8, "rate clamp");
      wreg(8'h10, 32'h83);
      wreg(8'h18, 32'hFA);
      wreg(8'h14, 32'h0);
      rchk(8'h1C, 32'h28, "energy assoc");
      n = p2;
      for (int i = 0; i < 8; i++) begin
         evt(3'h0, 8'h00, 4'h4);
         evt(3'h0, 8'h00, 4'hB);
      end
      idle(5);
      chk("energy pulses", n + 32'h2, p2);
      done("energy");
      // latched hold, retained across power loss
      wreg(8'h00, 32'h010A);
      wreg(8'h10, 32'h8);
      evt(3'h0, 8'h01, 4'h0);
      wreg(8'h1C, 32'h1);
      wreg(8'h0C, 32'h2);
      wreg(8'h1C, 32'h2);
      idle(4);
      chk("held pins", 32'h3, {30'h0, out2, out1});
      chk("keep", 32'h3, {30'h0, keep_out});
      keep_in <= keep_out;
      do_reset();
      idle(1);
      chk("pins after loss", 32'h0, {30'h0, out2, out1});
      wreg(8'h00, 32'h010A);
      wreg(8'h10, 32'h8);
      @(posedge clk);
      restore <= 1'b1;
      @(posedge clk);
      restore <= 1'b0;
      idle(4);
      chk("restored pins", 32'h3, {30'h0, out2, out1});
      wreg(8'h0C, 32'h4);
      wreg(8'h1C, 32'h4);
      idle(4);
      chk("released pins", 32'h0, {30'h0, out2, out1});
      done("hold");
      stop_test();
   end

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test();
   end
endmodule

bind dgout_top dgout_checker #(.SEC_CYCLES(SEC_CYCLES)) i_dgout_checker (
   .CLK(CLK), .RST_B(RST_B), .WR(WR), .RD(RD), .RDATA(RDATA),
   .DEMAND_END(DEMAND_END), .ALARM_TRIG(ALARM_TRIG), .ENERGY_TICK(ENERGY_TICK),
   .HOLD_RESTORE(HOLD_RESTORE), .HOLD_KEEP_OUT(HOLD_KEEP_OUT),
   .SWITCHED_OUTPUT_ONE(SWITCHED_OUTPUT_ONE), .SWITCHED_OUTPUT_TWO(SWITCHED_OUTPUT_TWO));
`default_nettype wire
